// ---- rtl/supervisor_cfg.svh ----
// timing and width constants for the supply supervisor
// assumes a 200 MHz system clock drives every counter
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH
// clock period in ps
`define SUP_CLK_PERIOD_PS 5000
// reset pulse width, typical, in ms
`define SUP_RST_PULSE_MS 200
// least brownout continuation, in ms
`define SUP_RST_MIN_MS 140
// watchdog timeout, typical, in ms
`define SUP_WD_TIMEOUT_MS 1600
// cycles per ms at 200 MHz
`define SUP_CYC_PER_MS (1000000000 / `SUP_CLK_PERIOD_PS)
`define SUP_RST_CYCLES (`SUP_RST_PULSE_MS * `SUP_CYC_PER_MS)
`define SUP_RST_MIN_CYCLES (`SUP_RST_MIN_MS * `SUP_CYC_PER_MS)
`define SUP_WD_CYCLES (`SUP_WD_TIMEOUT_MS * `SUP_CYC_PER_MS)
// counter width, enough for 320e6 cycles
`define SUP_CNT_W 32
`endif

// ---- rtl/supervisor_pkg.sv ----
// types for the supply supervisor
// assumes supervisor_cfg.svh is on the include path
`include "supervisor_cfg.svh"
package supervisor_pkg;
   typedef logic [`SUP_CNT_W-1:0] count_t;
   // reset sequencer states, gray along the usual path
   typedef enum logic [1:0]
   {
      st_hold = 2'b00,
      st_pulse = 2'b01,
      st_run = 2'b11
   } reset_state_e;
endpackage : supervisor_pkg

// ---- rtl/supervisor_sync2.sv ----
// two-flop synchroniser for pin inputs
// assumes the source is asynchronous to clk_sys_in
`timescale 1ns/1ps
module supervisor_sync2
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic async_in,
   output logic sync_out
);
   logic meta;
   // first stage is read only by the second
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         meta <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule : supervisor_sync2

// ---- rtl/supply_reset_and_watchdog_supervisor.sv ----
// supply supervisor: reset sequencer and independent watchdog
// assumes an analog comparator gives supply_low_in and a pad gives kick state
// Function
// - driven kick not toggled within 1.6 s drives watchdog output low
// - watchdog timer held clear while reset asserted or kick floating
// - timer counts once reset released and kick driven high or low
// - reset low from 1.2 V supply and while below threshold
// - reset released about 200 ms after supply rises above threshold
// - reset pulses low every time supply drops below threshold
// - brownout during a pulse continues it for at least 140 ms
// - on power-down reset stays low while supply is below threshold
// - active-high reset is the inverse of active-low reset
// - open-drain reset pulls low when asserted, else floats, same timing
// - supply below threshold drives watchdog output low regardless
// - reset asserts together with low-supply watchdog output
// - with kick floating, watchdog output is a low-line indicator only
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
module supply_reset_and_watchdog_supervisor
   import supervisor_pkg::*;
#(
   parameter count_t RST_CYCLES = count_t'(`SUP_RST_CYCLES),
   parameter count_t RST_MIN_CYCLES = count_t'(`SUP_RST_MIN_CYCLES),
   parameter count_t WD_CYCLES = count_t'(`SUP_WD_CYCLES)
)
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic supply_low_in,
   input wire logic watchdog_kick_in,
   input wire logic watchdog_kick_driven_in,
   output logic system_reset_n_out,
   output logic system_reset_out,
   output logic system_reset_open_drain_n_out,
   output logic system_reset_open_drain_n_oe_out,
   output logic watchdog_alarm_out_n
);
   // ************************************************************
   // input synchronisation
   // ************************************************************
   logic low_sync;
   logic kick_sync;
   logic driven_sync;
   logic kick_prev;
   reset_state_e state;
   count_t rst_cnt;
   count_t wd_cnt;
   logic wd_expired;
   logic reset_asserted;
   logic kick_edge;

   // every pin crosses two flops, so outputs trail a supply pin change by three edges and a kick or driven pin change by four
   // comparator output arrives as a plain level
   supervisor_sync2 u_sync_low
   (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .async_in(supply_low_in),
      .sync_out(low_sync)
   );
   supervisor_sync2 u_sync_kick
   (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .async_in(watchdog_kick_in),
      .sync_out(kick_sync)
   );
   supervisor_sync2 u_sync_driven
   (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .async_in(watchdog_kick_driven_in),
      .sync_out(driven_sync)
   );

   // ************************************************************
   // reset sequencer
   // ************************************************************
   // state holds the output low, from power-on until the pulse completes
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state <= st_hold;
         rst_cnt <= '0;
      end
      else
      begin
         case (state)
            st_hold:
            begin
               rst_cnt <= '0;
               if (!low_sync)
               begin
                  state <= st_pulse;
               end
            end
            st_pulse:
            begin
               if (low_sync)
               begin
                  // brownout mid-pulse: keep low, finish at least the minimum later
                  // capped, not cleared, so a late brownout lengthens the pulse
                  if (rst_cnt > RST_CYCLES - RST_MIN_CYCLES)
                  begin
                     rst_cnt <= RST_CYCLES - RST_MIN_CYCLES;
                  end
               end
               else if (rst_cnt >= RST_CYCLES - count_t'(1))
               begin
                  state <= st_run;
               end
               else
               begin
                  rst_cnt <= rst_cnt + count_t'(1);
               end
            end
            st_run:
            begin
               if (low_sync)
               begin
                  state <= st_hold;
               end
            end
            default:
            begin
               // only an upset state lands here; restart the power-up hold
               state <= st_hold;
            end
         endcase
      end
   end

   // supply low forces reset in the same cycle the alarm drops
   assign reset_asserted = (state != st_run) || low_sync;

   // ************************************************************
   // watchdog timer
   // ************************************************************
   // previous kick level, for edge detection on the synced copy
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         kick_prev <= 1'b0;
      end
      else
      begin
         kick_prev <= kick_sync;
      end
   end

   // any change of the synchronised level counts as one kick
   assign kick_edge = kick_sync ^ kick_prev;

   // expiry latches until a kick, reset or float; the processor must clear it by toggling
   // a kick on the edge the count runs out still wins: the processor was just in time
   // limitation: a floating pin is known only from the driven flag, never from its level
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wd_cnt <= '0;
         wd_expired <= 1'b0;
      end
      else if (reset_asserted || !driven_sync)
      begin
         wd_cnt <= '0;
         wd_expired <= 1'b0;
      end
      else if (kick_edge)
      begin
         wd_cnt <= '0;
         wd_expired <= 1'b0;
      end
      else if (wd_cnt >= WD_CYCLES - count_t'(1))
      begin
         wd_expired <= 1'b1;
      end
      else
      begin
         wd_cnt <= wd_cnt + count_t'(1);
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // registered so all three reset forms change on the same edge
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         system_reset_n_out <= 1'b0;
         system_reset_out <= 1'b1;
         system_reset_open_drain_n_oe_out <= 1'b1;
      end
      else
      begin
         system_reset_n_out <= !reset_asserted;
         system_reset_out <= reset_asserted;
         system_reset_open_drain_n_oe_out <= reset_asserted;
      end
   end

   // alarm moves on the reset edge, so a low-supply alarm meets a processor already in reset
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         watchdog_alarm_out_n <= 1'b1;
      end
      else
      begin
         watchdog_alarm_out_n <= !(wd_expired || low_sync);
      end
   end

   // open drain only ever drives low
   // the pad pulls low only while its enable is high; a pull-up gives the released level
   assign system_reset_open_drain_n_out = 1'b0;
endmodule : supply_reset_and_watchdog_supervisor

// ---- tb/supervisor_props.sv ----
// assertions on the supervisor top ports
// assumes bind below and short sim counts
`timescale 1ns/1ps
module supervisor_props
   import supervisor_pkg::*;
#(
   parameter count_t RST_CYCLES = 32'h64,
   parameter count_t RST_MIN_CYCLES = 32'h46,
   parameter count_t WD_CYCLES = 32'hc8
)
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic supply_low_in,
   input wire logic watchdog_kick_in,
   input wire logic watchdog_kick_driven_in,
   input wire logic system_reset_n_out,
   input wire logic system_reset_out,
   input wire logic system_reset_open_drain_n_out,
   input wire logic system_reset_open_drain_n_oe_out,
   input wire logic watchdog_alarm_out_n
);
   // ****
   // helper counters
   // ****
   count_t good;
   count_t quiet;
   logic kick_seen;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // good supply cycles; saturates so it never wraps
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in) good <= '0;
      else if (supply_low_in) good <= '0;
      else if (good != '1) good <= good + count_t'(1);
   // kick level one edge back, to spot a toggle on the pin
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in) kick_seen <= 1'b0;
      else kick_seen <= watchdog_kick_in;
   // cycles of a driven kick that has not moved while out of reset
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
      if (!rst_n_in) quiet <= '0;
      else if (!system_reset_n_out || !watchdog_kick_driven_in) quiet <= '0;
      else if (watchdog_kick_in != kick_seen) quiet <= '0;
      else if (quiet != '1) quiet <= quiet + count_t'(1);
   inv_reset_a: assert property (system_reset_out == !system_reset_n_out)
      else $error("active-high reset not inverse");
   open_drain_a: assert property (
      system_reset_open_drain_n_oe_out == !system_reset_n_out && !system_reset_open_drain_n_out)
      else $error("open-drain reset mismatch");
   low_supply_a: assert property (
      supply_low_in[*5] |-> !system_reset_n_out && !watchdog_alarm_out_n)
      else $error("low supply not flagged");
   same_moment_a: assert property ($fell(system_reset_n_out) |-> !watchdog_alarm_out_n)
      else $error("reset fell without alarm");
   min_pulse_a: assert property ($rose(system_reset_n_out) |-> good >= RST_MIN_CYCLES)
      else $error("reset pulse too short");
   max_pulse_a: assert property (good == RST_CYCLES + 8 |-> system_reset_n_out)
      else $error("reset pulse too long");
   wd_early_a: assert property (
      $fell(watchdog_alarm_out_n) && system_reset_n_out |-> quiet >= WD_CYCLES - 4)
      else $error("watchdog fired early");
   wd_late_a: assert property (quiet == WD_CYCLES + 10 |-> !watchdog_alarm_out_n)
      else $error("watchdog did not fire");
   float_quiet_a: assert property (
      (!watchdog_kick_driven_in && !supply_low_in)[*5] |-> watchdog_alarm_out_n)
      else $error("alarm with kick floating");
endmodule : supervisor_props
bind supply_reset_and_watchdog_supervisor supervisor_props #(.RST_CYCLES(RST_CYCLES),
   .RST_MIN_CYCLES(RST_MIN_CYCLES), .WD_CYCLES(WD_CYCLES)) supervisor_props_inst
(
   .clk_sys_in(clk_sys_in),
   .rst_n_in(rst_n_in),
   .supply_low_in(supply_low_in),
   .watchdog_kick_in(watchdog_kick_in),
   .watchdog_kick_driven_in(watchdog_kick_driven_in),
   .system_reset_n_out(system_reset_n_out),
   .system_reset_out(system_reset_out),
   .system_reset_open_drain_n_out(system_reset_open_drain_n_out),
   .system_reset_open_drain_n_oe_out(system_reset_open_drain_n_oe_out),
   .watchdog_alarm_out_n(watchdog_alarm_out_n)
);

// ---- tb/processor_model.sv ----
// processor model kicking the watchdog
// assumes the bench commands hangs and floats on purpose
`timescale 1ns/1ps
module processor_model
(
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic hang_in,
   input wire logic float_in,
   output logic kick_out = 1'b0,
   output logic kick_driven_out = 1'b0
);
   int gap = 0;
   logic level = 1'b0;
   // a floating pad reads noise, so it flips every cycle
   always @(posedge clk_sys_in)
   begin
      gap <= (gap == 49) ? 0 : gap + 1;
      if (reset_n_in && !hang_in && gap == 0) level <= !level;
      kick_driven_out <= !float_in;
      kick_out <= float_in ? !kick_out : level;
   end
endmodule : processor_model

// ---- tb/tb_supply_reset_and_watchdog_supervisor.sv ----
// self-checking bench for the supply supervisor
// assumes counts of 100, 70 and 200 cycles
`timescale 1ns/1ps
module tb_supply_reset_and_watchdog_supervisor;
   localparam int RC = 32'h64;
   localparam int WC = 32'hc8;
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic supply_low_in = 1'b1;
   logic hang = 1'b0;
   logic float_kick = 1'b0;
   logic kick, driven, reset_n, reset_hi, od_n, od_oe, alarm_n;
   int mismatches = 0;
   int n_checks = 0;
   int n;
   supply_reset_and_watchdog_supervisor #(.RST_CYCLES(32'h64), .RST_MIN_CYCLES(32'h46),
      .WD_CYCLES(32'hc8)) supply_reset_and_watchdog_supervisor_inst (.clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in), .supply_low_in(supply_low_in), .watchdog_kick_in(kick),
      .watchdog_kick_driven_in(driven), .system_reset_n_out(reset_n),
      .system_reset_out(reset_hi), .system_reset_open_drain_n_out(od_n),
      .system_reset_open_drain_n_oe_out(od_oe), .watchdog_alarm_out_n(alarm_n));
   processor_model processor_model_inst (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n),
      .hang_in(hang), .float_in(float_kick), .kick_out(kick), .kick_driven_out(driven));
   // ****
   // shared tasks
   // ****
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // sel 0 waits for reset release, 1 for alarm low, 2 for reset low
   task automatic wait_for(input int sel, output int k);
      k = 0;
      while ((sel == 0 ? reset_n : sel == 1 ? !alarm_n : !reset_n) !== 1'b1 && k < 900)
      begin
         @(negedge clk_sys_in);
         k++;
      end
   endtask : wait_for
   task automatic supply(input logic v, input int cycles);
      @(posedge clk_sys_in) supply_low_in <= v;
      repeat (cycles) @(negedge clk_sys_in);
   endtask : supply
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   // ****
   // scenarios
   // ****
   task automatic t_powerup;
      check({reset_n, reset_hi, od_oe, od_n, alarm_n}, 5'h0c);
      supply(1'b0, 0);
      wait_for(0, n);
      check(n >= RC && n <= RC + 8, 1);
      check({reset_hi, od_oe, alarm_n}, 3'h1);
   endtask : t_powerup
   task automatic t_brownout;
      supply(1'b1, 0);
      wait_for(2, n);
      check({n <= 4, alarm_n}, 2'h2);
      supply(1'b0, 0);
      wait_for(0, n);
      check(n >= RC && n <= RC + 8, 1);
   endtask : t_brownout
   task automatic t_midpulse;
      supply(1'b1, 10);
      supply(1'b0, 50);
      supply(1'b1, 10);
      supply(1'b0, 0);
      wait_for(0, n);
      check(n >= 32'h46 && n <= RC + 8, 1);
   endtask : t_midpulse
   task automatic t_kick;
      @(posedge clk_sys_in) hang <= 1'b1;
      wait_for(1, n);
      check(n >= WC - 50 && n <= WC + 8 && reset_n, 1);
      @(posedge clk_sys_in) float_kick <= 1'b1;
      repeat (3 * WC) @(negedge clk_sys_in);
      check(alarm_n, 1);
      @(posedge clk_sys_in) float_kick <= 1'b0;
      wait_for(1, n);
      check(n >= WC && n <= WC + 8, 1);
      @(posedge clk_sys_in) hang <= 1'b0;
      repeat (60) @(negedge clk_sys_in);
      check(alarm_n, 1);
   endtask : t_kick
   // clock, then the run and a watchdog on it
   initial forever #2.5 clk_sys_in = ~clk_sys_in;
   initial
   begin
      repeat (6) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      repeat (6) @(negedge clk_sys_in);
      t_powerup();
      t_kick();
      t_brownout();
      t_midpulse();
      test_done();
   end
   initial
   begin
      repeat (6000) @(posedge clk_sys_in);
      mismatches++;
      test_done();
   end
endmodule : tb_supply_reset_and_watchdog_supervisor
